// [inc/eid_pkg.sv]
/*
  Package for the extended indexed decode block: opcode patterns, field
  positions, address limits and carrier structs.
  Assumes a 16-bit program word, 12-bit data addresses and 8-bit file fields.
*/
package eid_pkg;

  // ---------------------------------------------------------------------
  // Widths and encodings
  // ---------------------------------------------------------------------
  localparam int OPC_W = 16;
  localparam int ADDR_W = 12;
  localparam int PC_W = 21;
  localparam logic [9:0] SUBLIT_TOP = 10'h3a4;
  localparam logic [1:0] SEL_FRAME = 2'h3;
  localparam int SEL_HI = 7;
  localparam int SEL_LO = 6;
  localparam int LIT_HI = 5;
  localparam int ACC_BIT = 8;
  localparam int DEST_BIT = 9;
  localparam logic [7:0] OFS_LIMIT = 8'h5f;
  localparam logic [3:0] ACC_HI_BANK = 4'hf;
  localparam logic [11:0] FRAME_RST = 12'h000;
  localparam logic [1:0] Q_LAST = 2'h3;

  // ---------------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------------
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic dest_file;
    logic indexed;
    logic valid;
  } eid_oper_s;

  typedef struct packed {
    logic [PC_W-1:0] pc;
    logic load;
  } eid_ret_s;

endpackage

// [hw/eid_addr_gen.sv]
/*
  Address generator for byte and bit oriented operands.
  Assumes the caller supplies the frame pointer from the same clock domain.
*/
`timescale 1ns/1ns
module eid_addr_gen (
  input wire logic ext_en,
  input wire logic [eid_pkg::OPC_W-1:0] opcode,
  input wire logic [3:0] bank_select_reg,
  input wire logic [eid_pkg::ADDR_W-1:0] stack_frame_pointer,
  output logic [eid_pkg::ADDR_W-1:0] addr,
  output logic indexed
);

  logic [7:0] fld;
  logic acc;

  assign fld = opcode[7:0];
  assign acc = opcode[eid_pkg::ACC_BIT];

  always_comb begin
    indexed = ext_en && !acc && (fld <= eid_pkg::OFS_LIMIT);
    if (indexed) begin
      addr = stack_frame_pointer + {4'h0, fld};
    end else if (acc) begin
      addr = {bank_select_reg, fld};
    end else if (fld[7]) begin
      addr = {eid_pkg::ACC_HI_BANK, fld};
    end else begin
      addr = {4'h0, fld};
    end
  end

endmodule

// [hw/eid_decode.sv]
/*
  Decoder for the frame subtract-and-return instruction and operand address
  generation for byte and bit oriented instructions.
  Assumes one opcode per instruction cycle, marked by q_phase wrapping to 0,
  and a core that pops the return stack when ret.load is seen.
*/
// How it works
// - Subtract 6-bit literal 0..63 from frame pointer and store.
// - Then return: program counter loads from return stack top.
// - One word, two cycles; second cycle is a full no-op.
// - Decoded as pointer-literal-subtract with select bits 11, no flags.
// - Extended enable unlocks extra opcodes and indexed offset mode.
// - Disabled: access bit 0 access bank, 1 bank select bank.
// - Enabled, access 0, field up to 5Fh is pointer offset.
// - Reinterpretation covers all byte and bit oriented instructions alike.
// - Zero pointer reproduces the original access bank addresses.
// - Indexed address is pointer plus offset, for source and destination.
// - Destination bit keeps choosing working register or file.
`timescale 1ns/1ns
module eid_decode (
  input wire logic clock,
  input wire logic srst,
  input wire logic ext_en_pin,
  input wire logic [1:0] q_phase,
  input wire logic [eid_pkg::OPC_W-1:0] opcode,
  input wire logic [3:0] bank_select_reg,
  input wire logic [eid_pkg::PC_W-1:0] return_stack_top,
  output logic [eid_pkg::ADDR_W-1:0] stack_frame_pointer,
  output eid_pkg::eid_oper_s oper,
  output eid_pkg::eid_ret_s ret,
  output logic nop_cycle,
  output logic flags_we
);

  // ---------------------------------------------------------------------
  // Enable sampling
  // ---------------------------------------------------------------------
  logic ext_meta_ff;
  logic ext_en_ff;

  always_ff @(posedge clock) begin
    if (srst) begin
      ext_meta_ff <= 1'b0;
      ext_en_ff <= 1'b0;
    end else begin
      ext_meta_ff <= ext_en_pin;
      ext_en_ff <= ext_meta_ff;
    end
  end

  // ---------------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------------
  function automatic logic is_sublit(input logic [eid_pkg::OPC_W-1:0] op);
    is_sublit = (op[15:6] & 10'h3fc) == eid_pkg::SUBLIT_TOP;
  endfunction

  function automatic logic has_access_bit(input logic [eid_pkg::OPC_W-1:0] op);
    // Byte ops 0000-0110 (minus 0000 00) and bit ops 1000-1011
    case (op[15:12])
      4'h0: has_access_bit = (op[11:10] != 2'h0);
      4'h1, 4'h2, 4'h3: has_access_bit = 1'b1;
      4'h4, 4'h5, 4'h6: has_access_bit = 1'b1;
      4'h8, 4'h9, 4'ha, 4'hb: has_access_bit = 1'b1;
      default: has_access_bit = 1'b0;
    endcase
  endfunction

  typedef enum {ST_EXEC, ST_NOP} eid_state_e;
  eid_state_e state_ff;
  eid_state_e nxt_state;
  logic start;
  logic cyc_end;
  logic sub_ret;
  logic [5:0] lit;

  assign cyc_end = (q_phase == eid_pkg::Q_LAST);
  assign sub_ret = ext_en_ff && is_sublit(opcode)
    && opcode[eid_pkg::SEL_HI:eid_pkg::SEL_LO] == eid_pkg::SEL_FRAME;
  assign start = (state_ff == ST_EXEC) && cyc_end && sub_ret;
  assign lit = opcode[eid_pkg::LIT_HI:0];

  always_comb begin
    case (state_ff)
      ST_EXEC: nxt_state = start ? ST_NOP : ST_EXEC;
      ST_NOP: nxt_state = cyc_end ? ST_EXEC : ST_NOP;
      default: nxt_state = ST_EXEC;
    endcase
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      state_ff <= ST_EXEC;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign nop_cycle = (state_ff == ST_NOP);
  assign flags_we = 1'b0;

  // ---------------------------------------------------------------------
  // Frame pointer
  // ---------------------------------------------------------------------
  logic [eid_pkg::ADDR_W-1:0] frame_ptr_ff;
  logic [eid_pkg::ADDR_W-1:0] nxt_frame_ptr;

  // pointer minus literal
  // Literal zero extended; difference wraps in 12 bits
  assign nxt_frame_ptr = frame_ptr_ff - {6'h00, lit};

  // Only the taken edge moves it; the no-op cycle leaves it alone
  always_ff @(posedge clock) begin
    if (srst) begin
      frame_ptr_ff <= eid_pkg::FRAME_RST;
    end else if (start) begin
      frame_ptr_ff <= nxt_frame_ptr;
    end
  end

  assign stack_frame_pointer = frame_ptr_ff;

  // ---------------------------------------------------------------------
  // Return request
  // ---------------------------------------------------------------------
  logic ret_load_ff;
  logic [eid_pkg::PC_W-1:0] ret_pc_ff;

  // return after update
  // One-cycle pulse; the core pops its return stack on it
  always_ff @(posedge clock) begin
    if (srst) begin
      ret_load_ff <= 1'b0;
    end else begin
      ret_load_ff <= start;
    end
  end

  // Target holds after the pulse so a slow fetch can still use it
  always_ff @(posedge clock) begin
    if (srst) begin
      ret_pc_ff <= '0;
    end else if (start) begin
      ret_pc_ff <= return_stack_top;
    end
  end

  assign ret = '{pc: ret_pc_ff, load: ret_load_ff};

  // ---------------------------------------------------------------------
  // Operand address
  // ---------------------------------------------------------------------
  logic [eid_pkg::ADDR_W-1:0] gen_addr;
  logic gen_idx;
  logic acc_op;
  logic oper_valid_ff;
  logic [eid_pkg::ADDR_W-1:0] oper_addr_ff;
  logic oper_idx_ff;
  logic oper_dest_ff;

  assign acc_op = has_access_bit(opcode);

  eid_addr_gen u_addr (
    .ext_en(ext_en_ff),
    .opcode(opcode),
    .bank_select_reg(bank_select_reg),
    .stack_frame_pointer(stack_frame_pointer),
    .addr(gen_addr),
    .indexed(gen_idx)
  );

  // same rule for all such ops
  always_ff @(posedge clock) begin
    if (srst) begin
      oper_valid_ff <= 1'b0;
    end else begin
      oper_valid_ff <= (state_ff == ST_EXEC) && acc_op;
    end
  end

  // Address runs every cycle; the core ignores it while valid is low
  always_ff @(posedge clock) begin
    if (srst) begin
      oper_addr_ff <= '0;
    end else begin
      oper_addr_ff <= gen_addr;
    end
  end

  // Indexed only means something for ops that carry the access bit
  always_ff @(posedge clock) begin
    if (srst) begin
      oper_idx_ff <= 1'b0;
    end else begin
      oper_idx_ff <= gen_idx && acc_op;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      oper_dest_ff <= 1'b0;
    end else begin
      oper_dest_ff <= opcode[eid_pkg::DEST_BIT];
    end
  end

  assign oper = '{
    addr: oper_addr_ff,
    dest_file: oper_dest_ff,
    indexed: oper_idx_ff,
    valid: oper_valid_ff
  };

endmodule

// [verif/eid_decode_asserts.sv]
/* Checker on the eid_decode ports.
   Assumes the enable pin stays static while code runs. */
`timescale 1ns/1ns
module eid_chk (
  input wire logic clock,
  input wire logic srst,
  input wire logic ext_en_pin,
  input wire logic [1:0] q_phase,
  input wire logic [15:0] opcode,
  input wire logic [3:0] bank_select_reg,
  input wire logic [20:0] return_stack_top,
  input wire logic [11:0] stack_frame_pointer,
  input wire eid_pkg::eid_oper_s oper,
  input wire eid_pkg::eid_ret_s ret,
  input wire logic nop_cycle,
  input wire logic flags_we
);
  logic [1:0] en_ff;
  logic take;
  logic byte_op;
  // Same two-flop delay as the enable path
  always_ff @(posedge clock) begin
    en_ff <= srst ? 2'h0 : {en_ff[0], ext_en_pin};
  end
  assign take = q_phase == 2'h3 && opcode[15:6] == 10'h3a7 && !nop_cycle && en_ff[1];
  assign byte_op = opcode[15:12] == 4'h2 && !nop_cycle;
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  // ------------
  // Properties
  // ------------
  a_ptr_sub: assert property (take |=> stack_frame_pointer ==
    $past(stack_frame_pointer) - {6'h0, $past(opcode[5:0])}) else $error("bad pointer");
  a_ptr_hold: assert property (!take |=> $stable(stack_frame_pointer))
    else $error("pointer moved");
  a_ret_load: assert property (take |=> ret.load && ret.pc == $past(return_stack_top))
    else $error("no return");
  a_nop_span: assert property (take |=> nop_cycle [*4] ##1 !nop_cycle)
    else $error("bad no-op cycle");
  a_load_pulse: assert property (ret.load |=> !ret.load) else $error("long load");
  a_flags_off: assert property (flags_we == 1'b0) else $error("flag write");
  a_sel_other: assert property (opcode[15:8] == 8'he9 && opcode[7:6] != 2'h3
    |=> !ret.load) else $error("wrong select taken");
  a_ext_off: assert property (!en_ff[1] |=> !ret.load) else $error("taken when off");
  a_idx_addr: assert property (byte_op && en_ff[1] && !opcode[8] && opcode[7:0] <= 8'h5f
    |=> oper.indexed && oper.addr == $past(stack_frame_pointer) + $past(opcode[7:0]))
    else $error("bad indexed address");
  a_bank_addr: assert property (byte_op && opcode[8] |=> oper.dest_file ==
    $past(opcode[9]) && oper.addr == {$past(bank_select_reg), $past(opcode[7:0])})
    else $error("bad banked address");
endmodule
bind eid_decode eid_chk u_chk (
  .clock(clock),
  .srst(srst),
  .ext_en_pin(ext_en_pin),
  .q_phase(q_phase),
  .opcode(opcode),
  .bank_select_reg(bank_select_reg),
  .return_stack_top(return_stack_top),
  .stack_frame_pointer(stack_frame_pointer),
  .oper(oper),
  .ret(ret),
  .nop_cycle(nop_cycle),
  .flags_we(flags_we)
);

// [verif/tb_extended_indexed_decode.sv]
/* Bench for eid_decode.
   Assumes four clocks per instruction cycle, opcode held for each. */
`timescale 1ns/1ns
module tb_extended_indexed_decode;
  logic clock = 1'b0;
  logic srst = 1'b1;
  logic ext_en_pin = 1'b1;
  logic [1:0] q_phase = 2'h0;
  logic [15:0] opcode = 16'h0000;
  logic [3:0] bank_select_reg = 4'h5;
  logic [20:0] return_stack_top = 21'h1abcd;
  logic [11:0] stack_frame_pointer;
  eid_pkg::eid_oper_s oper;
  eid_pkg::eid_ret_s ret;
  logic nop_cycle;
  logic flags_we;
  int err_total = 0;
  int check_count = 0;
  eid_decode dut (
    .clock(clock),
    .srst(srst),
    .ext_en_pin(ext_en_pin),
    .q_phase(q_phase),
    .opcode(opcode),
    .bank_select_reg(bank_select_reg),
    .return_stack_top(return_stack_top),
    .stack_frame_pointer(stack_frame_pointer),
    .oper(oper),
    .ret(ret),
    .nop_cycle(nop_cycle),
    .flags_we(flags_we)
  );
  initial begin
    forever #2 clock = ~clock;
  end
  always @(posedge clock) begin
    q_phase <= srst ? 2'h0 : q_phase + 2'h1;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask
  // Opcode lands at a cycle start; returns after its last phase
  task automatic run(input logic [15:0] op);
    do @(posedge clock); while (q_phase != 2'h3);
    opcode <= op;
    do @(posedge clock); while (q_phase != 2'h3);
    #1;
  endtask
  // ------------
  // Scenarios
  // ------------
  task automatic t_addr();
    run(16'h2405);
    chk(oper.addr, 12'h005);
    chk({oper.dest_file, oper.indexed, oper.valid}, 3'h3);
    run(16'h2460);
    chk(oper.addr, 12'h060);
    run(16'h2485);
    chk(oper.addr, 12'hf85);
    run(16'h2710);
    chk({oper.dest_file, oper.addr}, 13'h1510);
  endtask
  task automatic t_sub();
    run(16'he9ff);
    chk(stack_frame_pointer, 12'hfc1);
    chk({ret.load, ret.pc}, 22'h21abcd);
    chk({nop_cycle, flags_we, oper.valid}, 3'h4);
    run(16'he9e3);
    chk(stack_frame_pointer, 12'hf9e);
    run(16'he9a3);
    chk({ret.load, stack_frame_pointer}, 13'h0f9e);
    run(16'h8005);
    chk({oper.valid, oper.indexed, oper.addr}, 14'h3fa3);
  endtask
  task automatic t_off();
    @(posedge clock);
    ext_en_pin <= 1'b0;
    run(16'h2405);
    chk({oper.indexed, oper.addr}, 13'h0005);
    run(16'he9c5);
    chk({ret.load, stack_frame_pointer}, 13'h0f9e);
  endtask
  task automatic finish_test();
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    repeat (2000) @(posedge clock);
    err_total++;
    finish_test();
  end
  initial begin
    repeat (12) @(posedge clock);
    srst <= 1'b0;
    t_addr();
    t_sub();
    t_off();
    finish_test();
  end
endmodule
